// file: ds1_idle_loop_pkg.sv
// Package: register map, field layout, reset values and mode types for the idle/loopback bank
package ds1_idle_loop_pkg;
	localparam int ADDR_WIDTH = 6;
	localparam int DATA_WIDTH = 8;
	localparam int GROUP_BITS = 7;
	localparam int GROUP_COUNT = 3;
	localparam int CHAN_COUNT = GROUP_BITS * GROUP_COUNT;
	localparam int DS2_COUNT = 7;
	localparam int READ_BUF_DEPTH = 2;
	localparam int PATTERN_COUNT = 4;

	localparam logic [ADDR_WIDTH-1:0] SEL_GROUP2_OFFSET = 6'h11;
	localparam logic [ADDR_WIDTH-1:0] SEL_GROUP3_OFFSET = 6'h12;
	localparam logic [ADDR_WIDTH-1:0] SEL_GROUP4_OFFSET = 6'h13;
	localparam logic [ADDR_WIDTH-1:0] RX_XBIT_OFFSET = 6'h14;
	localparam logic [ADDR_WIDTH-1:0] TX_XBIT_OFFSET = 6'h15;
	localparam logic [ADDR_WIDTH-1:0] ALARM_LATCH_OFFSET = 6'h16;

	localparam logic [GROUP_BITS-1:0] SEL_GROUP_RESET = 7'h00;
	localparam logic [DS2_COUNT-1:0] TX_XBIT_RESET = 7'h7F;
	localparam logic [DATA_WIDTH-1:0] ALARM_LATCH_RESET = 8'h00;
	localparam logic [DATA_WIDTH-1:0] UNMAPPED_READ_VALUE = 8'h00;

	// Latched alarm layout, bit positions
	localparam int ALARM_LOS_BIT = 7;
	localparam int ALARM_OOF_BIT = 6;
	localparam int ALARM_AIS_BIT = 5;
	localparam int ALARM_IDLE_BIT = 4;
	localparam int ALARM_RXCKF_BIT = 3;
	localparam int ALARM_TXCKF_BIT = 2;
	localparam int ALARM_XBIT2_BIT = 1;
	localparam int ALARM_XBIT1_BIT = 0;

	typedef enum logic [1:0] {
		SRC_PINS = 2'b00,
		SRC_IDLE = 2'b01,
		SRC_LOOP = 2'b10
	} chanSource_type;
endpackage

// file: read_skid_buffer.sv
// Two-entry valid/ready buffer carrying register read data to the host
`timescale 1ns/1ps
module read_skid_buffer import ds1_idle_loop_pkg::*; #(
	parameter int WIDTH = DATA_WIDTH,
	parameter int DEPTH = READ_BUF_DEPTH
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic inValid,
	output logic inReady,
	input wire logic [WIDTH-1:0] inData,
	output logic outValid,
	input wire logic outReady,
	output logic [WIDTH-1:0] outData
);
	localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [PTR_W-1:0] wrPtr_reg;
	logic [PTR_W-1:0] rdPtr_reg;
	logic [PTR_W:0] count_reg;
	logic push;
	logic pop;

	assign inReady = (count_reg != (PTR_W+1)'(DEPTH));
	assign outValid = (count_reg != '0);
	assign outData = mem_reg[rdPtr_reg];
	assign push = inValid && inReady;
	assign pop = outValid && outReady;

	always_ff @(posedge clk) begin
		if (push) begin
			mem_reg[wrPtr_reg] <= inData;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wrPtr_reg <= '0;
			rdPtr_reg <= '0;
			count_reg <= '0;
		end else begin
			if (push) begin
				wrPtr_reg <= (wrPtr_reg == PTR_W'(DEPTH - 1)) ? '0 : wrPtr_reg + 1'b1;
			end
			if (pop) begin
				rdPtr_reg <= (rdPtr_reg == PTR_W'(DEPTH - 1)) ? '0 : rdPtr_reg + 1'b1;
			end
			count_reg <= count_reg + (PTR_W+1)'(push) - (PTR_W+1)'(pop);
		end
	end
endmodule

// file: alarm_latch_bank.sv
// Sticky alarm bits with clear-on-read and relatch
`timescale 1ns/1ps
module alarm_latch_bank import ds1_idle_loop_pkg::*; (
	input wire logic clk,
	input wire logic rst,
	input wire logic [DATA_WIDTH-1:0] condition,
	input wire logic clearRead,
	output logic [DATA_WIDTH-1:0] latched
);
	logic [DATA_WIDTH-1:0] latch_reg;
	logic [DATA_WIDTH-1:0] latch_next;

	// A live condition always re-sets, so a clear never hides a standing alarm
	always_comb begin
		latch_next = clearRead ? '0 : latch_reg;
		latch_next = latch_next | condition;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			latch_reg <= ALARM_LATCH_RESET;
		end else begin
			latch_reg <= latch_next;
		end
	end

	assign latched = latch_reg;
endmodule

// file: ds1_idle_loop_regs.sv
// DS1 idle/loopback select, DS2 X-bit access and latched DS3 alarm register bank
`timescale 1ns/1ps
module ds1_idle_loop_regs import ds1_idle_loop_pkg::*; (
	input wire logic clk,
	input wire logic rst,
	input wire logic chipSelect,
	input wire logic [ADDR_WIDTH-1:0] regAddr,
	input wire logic writeStrobe,
	input wire logic [DATA_WIDTH-1:0] writeData,
	input wire logic readStrobe,
	output logic readAccept,
	output logic readValid,
	input wire logic readReady,
	output logic [DATA_WIDTH-1:0] readData,
	input wire logic idle_pattern_sel_hi,
	input wire logic idle_pattern_sel_lo,
	input wire logic [PATTERN_COUNT-1:0] idlePatternData,
	input wire logic idlePatternClock,
	input wire logic [CHAN_COUNT-1:0] loopConnect,
	input wire logic [CHAN_COUNT-1:0] ds1_tx_data_pin,
	input wire logic [CHAN_COUNT-1:0] ds1_tx_clock_pin,
	input wire logic [CHAN_COUNT-1:0] rxDemuxData,
	input wire logic [CHAN_COUNT-1:0] rxDemuxClock,
	output logic [CHAN_COUNT-1:0] txMuxData,
	output logic [CHAN_COUNT-1:0] txMuxClock,
	input wire logic [DS2_COUNT-1:0] rx_ds2_xbit,
	output logic [DS2_COUNT-1:0] tx_ds2_xbit,
	input wire logic ds3LossOfSignal,
	input wire logic ds3OutOfFrame,
	input wire logic ds3AlarmIndication,
	input wire logic ds3IdleDetect,
	input wire logic ds3RxClockFail,
	input wire logic ds3TxClockFail,
	input wire logic ds3RxXbit2,
	input wire logic ds3RxXbit1
);
	logic [GROUP_BITS-1:0] selGroup2_reg;
	logic [GROUP_BITS-1:0] selGroup3_reg;
	logic [GROUP_BITS-1:0] selGroup4_reg;
	logic [DS2_COUNT-1:0] txXbit_reg;
	logic [CHAN_COUNT-1:0] channel_idle_loop_select;
	logic [CHAN_COUNT-1:0] txData_reg;
	logic [CHAN_COUNT-1:0] txClock_reg;
	logic [1:0] patternIndex;
	logic idleBit;
	logic writeHit;
	logic readTake;
	logic alarmClear;
	logic [DATA_WIDTH-1:0] alarmCondition;
	logic [DATA_WIDTH-1:0] alarmLatched;
	logic [DATA_WIDTH-1:0] readWord;

	// Host port decode
	assign writeHit = chipSelect && writeStrobe;
	assign readTake = chipSelect && readStrobe && readAccept;
	// Clear only on a read that is really taken, so a refused read loses no alarm
	assign alarmClear = readTake && (regAddr == ALARM_LATCH_OFFSET);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			selGroup2_reg <= SEL_GROUP_RESET;
		end else if (writeHit && regAddr == SEL_GROUP2_OFFSET) begin
			selGroup2_reg <= writeData[GROUP_BITS-1:0];
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			selGroup3_reg <= SEL_GROUP_RESET;
		end else if (writeHit && regAddr == SEL_GROUP3_OFFSET) begin
			selGroup3_reg <= writeData[GROUP_BITS-1:0];
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			selGroup4_reg <= SEL_GROUP_RESET;
		end else if (writeHit && regAddr == SEL_GROUP4_OFFSET) begin
			selGroup4_reg <= writeData[GROUP_BITS-1:0];
		end
	end

	// Reset to all ones, the customary off state
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			txXbit_reg <= TX_XBIT_RESET;
		end else if (writeHit && regAddr == TX_XBIT_OFFSET) begin
			txXbit_reg <= writeData[DS2_COUNT-1:0];
		end
	end

	assign tx_ds2_xbit = txXbit_reg;

	// Channel index = group * 7 + bit: group 0 holds 2,6..26, group 1 3..27, group 2 4..28
	assign channel_idle_loop_select = {selGroup4_reg, selGroup3_reg, selGroup2_reg};

	// Idle code select bits pick one of the externally generated patterns
	assign patternIndex = {idle_pattern_sel_hi, idle_pattern_sel_lo};
	assign idleBit = idlePatternData[patternIndex];

	genvar ch;
	generate
		for (ch = 0; ch < CHAN_COUNT; ch++) begin : gen_chan
			chanSource_type source;

			always_comb begin
				if (!channel_idle_loop_select[ch]) begin
					source = SRC_PINS;
				end else if (loopConnect[ch]) begin
					source = SRC_LOOP;
				end else begin
					source = SRC_IDLE;
				end
			end

			// Registered so the transmit side sees clean flop outputs
			always_ff @(posedge clk or posedge rst) begin
				if (rst) begin
					txData_reg[ch] <= 1'b0;
					txClock_reg[ch] <= 1'b0;
				end else begin
					unique case (source)
						SRC_PINS: begin
							txData_reg[ch] <= ds1_tx_data_pin[ch];
							txClock_reg[ch] <= ds1_tx_clock_pin[ch];
						end
						SRC_LOOP: begin
							txData_reg[ch] <= rxDemuxData[ch];
							txClock_reg[ch] <= rxDemuxClock[ch];
						end
						SRC_IDLE: begin
							txData_reg[ch] <= idleBit;
							txClock_reg[ch] <= idlePatternClock;
						end
						default: begin
							txData_reg[ch] <= 1'b0;
							txClock_reg[ch] <= 1'b0;
						end
					endcase
				end
			end
		end
	endgenerate

	assign txMuxData = txData_reg;
	assign txMuxClock = txClock_reg;

	// Live alarm vector; the X-bits alarm when received as zero
	always_comb begin
		alarmCondition = '0;
		alarmCondition[ALARM_LOS_BIT] = ds3LossOfSignal;
		alarmCondition[ALARM_OOF_BIT] = ds3OutOfFrame;
		alarmCondition[ALARM_AIS_BIT] = ds3AlarmIndication;
		alarmCondition[ALARM_IDLE_BIT] = ds3IdleDetect;
		alarmCondition[ALARM_RXCKF_BIT] = ds3RxClockFail;
		alarmCondition[ALARM_TXCKF_BIT] = ds3TxClockFail;
		alarmCondition[ALARM_XBIT2_BIT] = !ds3RxXbit2;
		alarmCondition[ALARM_XBIT1_BIT] = !ds3RxXbit1;
	end

	alarm_latch_bank alarmBank (
		.clk(clk),
		.rst(rst),
		.condition(alarmCondition),
		.clearRead(alarmClear),
		.latched(alarmLatched)
	);

	// Read mux; bit 7 of the 7-bit registers and unmapped addresses read zero
	always_comb begin
		readWord = UNMAPPED_READ_VALUE;
		unique case (regAddr)
			SEL_GROUP2_OFFSET: readWord = {1'b0, selGroup2_reg};
			SEL_GROUP3_OFFSET: readWord = {1'b0, selGroup3_reg};
			SEL_GROUP4_OFFSET: readWord = {1'b0, selGroup4_reg};
			RX_XBIT_OFFSET: readWord = {1'b0, rx_ds2_xbit};
			TX_XBIT_OFFSET: readWord = {1'b0, txXbit_reg};
			ALARM_LATCH_OFFSET: readWord = alarmLatched;
			default: readWord = UNMAPPED_READ_VALUE;
		endcase
	end

	// Read data waits here while the host stalls; a full buffer refuses reads
	read_skid_buffer #(
		.WIDTH(DATA_WIDTH),
		.DEPTH(READ_BUF_DEPTH)
	) readBuf (
		.clk(clk),
		.rst(rst),
		.inValid(chipSelect && readStrobe),
		.inReady(readAccept),
		.inData(readWord),
		.outValid(readValid),
		.outReady(readReady),
		.outData(readData)
	);
endmodule

// file: ds1_line_model.sv
// Line-side model: DS1 transmit pins and demultiplexed receive channels
`timescale 1ns/1ps
module ds1_line_model import ds1_idle_loop_pkg::*; (
	input wire logic clk,
	output logic [CHAN_COUNT-1:0] ds1_tx_data_pin,
	output logic [CHAN_COUNT-1:0] ds1_tx_clock_pin,
	output logic [CHAN_COUNT-1:0] rxDemuxData,
	output logic [CHAN_COUNT-1:0] rxDemuxClock
);
	// Every line flips each cycle and the receive lines are the complement of the pins, so a stale source or a wrong registered source never matches
	// One process owns every line, so no line has two drivers
	initial begin
		ds1_tx_data_pin = 21'h0AAAAA;
		ds1_tx_clock_pin = 21'h1FFFFF;
		rxDemuxData = 21'h155555;
		rxDemuxClock = 21'h000000;
		forever begin
			@(posedge clk);
			ds1_tx_data_pin <= ~ds1_tx_data_pin;
			ds1_tx_clock_pin <= ~ds1_tx_clock_pin;
			rxDemuxData <= ~rxDemuxData;
			rxDemuxClock <= ~rxDemuxClock;
		end
	end
endmodule

// file: ds1_idle_loop_regs_properties.sv
// Port checker for the idle/loopback register bank
`timescale 1ns/1ps
module ds1_idle_loop_regs_checker import ds1_idle_loop_pkg::*; (
	input wire logic clk,
	input wire logic rst,
	input wire logic chipSelect,
	input wire logic [ADDR_WIDTH-1:0] regAddr,
	input wire logic writeStrobe,
	input wire logic [DATA_WIDTH-1:0] writeData,
	input wire logic readStrobe,
	input wire logic readAccept,
	input wire logic readValid,
	input wire logic readReady,
	input wire logic [DATA_WIDTH-1:0] readData,
	input wire logic [CHAN_COUNT-1:0] loopConnect,
	input wire logic [CHAN_COUNT-1:0] ds1_tx_data_pin,
	input wire logic [CHAN_COUNT-1:0] rxDemuxData,
	input wire logic [CHAN_COUNT-1:0] txMuxData,
	input wire logic [DS2_COUNT-1:0] tx_ds2_xbit,
	input wire logic ds3LossOfSignal
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	wire logic put = chipSelect && writeStrobe;
	wire logic take = chipSelect && readStrobe && readAccept;
	wire logic take16 = take && regAddr == ALARM_LATCH_OFFSET;
	logic chanSel_reg;
	// Mirror of channel 2 select, so path checks need no register read
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			chanSel_reg <= 1'h0;
		end else if (put && regAddr == SEL_GROUP2_OFFSET) begin
			chanSel_reg <= writeData[0];
		end
	end
	property p_tx_xbit;
		put && regAddr == TX_XBIT_OFFSET |=> tx_ds2_xbit == $past(writeData[6:0]);
	endproperty
	a_tx_xbit: assert property (p_tx_xbit) else $error("tx xbit differs from write");
	property p_answer;
		take |=> readValid;
	endproperty
	a_answer: assert property (p_answer) else $error("no word after accepted read");
	property p_stand;
		readValid && !readReady |=> readValid && $stable(readData);
	endproperty
	a_stand: assert property (p_stand) else $error("read word lost while stalled");
	property p_full;
		readValid && !readReady && take |=> !readAccept;
	endproperty
	a_full: assert property (p_full) else $error("read buffer takes a third word");
	property p_pins;
		!chanSel_reg |=> txMuxData[0] == $past(ds1_tx_data_pin[0]);
	endproperty
	a_pins: assert property (p_pins) else $error("unselected channel not from pins");
	property p_loop;
		chanSel_reg && loopConnect[0] |=> txMuxData[0] == $past(rxDemuxData[0]);
	endproperty
	a_loop: assert property (p_loop) else $error("loopback data wrong");
	property p_relatch;
		take16 && !readValid && ds3LossOfSignal ##1 take16 && readReady |=> readData[7];
	endproperty
	a_relatch: assert property (p_relatch) else $error("alarm lost at clear");
	property p_clear;
		take16 && !readValid && !ds3LossOfSignal ##1 take16 && readReady |=> !readData[7];
	endproperty
	a_clear: assert property (p_clear) else $error("alarm not cleared by read");
endmodule
bind ds1_idle_loop_regs ds1_idle_loop_regs_checker portCheck (.*);

// file: tb.sv
// Self-checking bench for the idle/loopback register bank
`timescale 1ns/1ps
module tb import ds1_idle_loop_pkg::*;;
	logic clk, rst, chipSelect, writeStrobe, readStrobe, readReady, readAccept, readValid;
	logic idle_pattern_sel_hi, idle_pattern_sel_lo, idlePatternClock;
	logic [ADDR_WIDTH-1:0] regAddr;
	logic [DATA_WIDTH-1:0] writeData, readData, live;
	logic [PATTERN_COUNT-1:0] idlePatternData;
	logic [CHAN_COUNT-1:0] loopConnect, ds1_tx_data_pin, ds1_tx_clock_pin, rxDemuxData;
	logic [CHAN_COUNT-1:0] rxDemuxClock, txMuxData, txMuxClock;
	logic [DS2_COUNT-1:0] rx_ds2_xbit, tx_ds2_xbit;
	int fails, checks;
	ds1_line_model farEnd (.*);
	ds1_idle_loop_regs dut (.*, .ds3LossOfSignal(live[7]), .ds3OutOfFrame(live[6]),
		.ds3AlarmIndication(live[5]), .ds3IdleDetect(live[4]), .ds3RxClockFail(live[3]),
		.ds3TxClockFail(live[2]), .ds3RxXbit2(~live[1]), .ds3RxXbit1(~live[0]));
	task automatic check(input logic [CHAN_COUNT-1:0] got, input logic [CHAN_COUNT-1:0] exp);
		checks++;
		if (got !== exp) begin
			fails++;
			$display("unexpected at %0t: got %h wanted %h", $time, got, exp);
		end
	endtask
	task automatic results();
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		@(posedge clk);
		chipSelect <= 1'h1;
		writeStrobe <= 1'h1;
		regAddr <= a;
		writeData <= d;
		@(posedge clk);
		chipSelect <= 1'h0;
		writeStrobe <= 1'h0;
	endtask
	// Sampled at the falling edge, so the taking edge never races the bench
	task automatic issue(input logic [5:0] a);
		int n = 0;
		@(posedge clk);
		chipSelect <= 1'h1;
		readStrobe <= 1'h1;
		regAddr <= a;
		do begin
			@(negedge clk);
			n++;
		end while (readAccept !== 1'h1 && n < 20);
		if (readAccept !== 1'h1) begin
			fails++;
			$display("unexpected at %0t: read never accepted", $time);
		end
		@(posedge clk);
		chipSelect <= 1'h0;
		readStrobe <= 1'h0;
	endtask
	task automatic pop(input logic [7:0] exp);
		int n = 0;
		@(posedge clk);
		readReady <= 1'h1;
		do begin
			@(negedge clk);
			n++;
		end while (readValid !== 1'h1 && n < 20);
		if (readValid !== 1'h1) begin
			fails++;
			$display("unexpected at %0t: no read word offered", $time);
		end
		check(readData, exp);
		@(posedge clk);
		readReady <= 1'h0;
	endtask
	task automatic rd(input logic [5:0] a, input logic [7:0] exp);
		issue(a);
		pop(exp);
	endtask
	initial begin
		clk = 1'h0;
		forever #25 clk = ~clk;
	end
	initial begin
		repeat (5000) @(posedge clk);
		fails++;
		results();
	end
	initial begin
		{fails, checks} = '0;
		{rst, idlePatternClock, idlePatternData, rx_ds2_xbit} = {1'h1, 1'h0, 4'h5, 7'h35};
		{chipSelect, writeStrobe, readStrobe, readReady, regAddr, writeData} = '0;
		{idle_pattern_sel_hi, idle_pattern_sel_lo, loopConnect, live} = '0;
		repeat (8) @(posedge clk);
		rst <= 1'h0;
		repeat (2) @(negedge clk);
		check(txMuxData, ~ds1_tx_data_pin);
		check(txMuxClock, ~ds1_tx_clock_pin);
		check(tx_ds2_xbit, 7'h7F);
		for (int g = 0; g < 3; g++) begin
			rd(SEL_GROUP2_OFFSET + 6'(g), 8'h00);
			wr(SEL_GROUP2_OFFSET + 6'(g), 8'hFF);
			rd(SEL_GROUP2_OFFSET + 6'(g), 8'h7F);
		end
		for (int c = 0; c < 4; c++) begin
			@(posedge clk);
			{idle_pattern_sel_hi, idle_pattern_sel_lo, idlePatternClock} <= 3'(c * 2 + c % 2);
			repeat (2) @(negedge clk);
			check(txMuxData, {CHAN_COUNT{idlePatternData[c]}});
			check(txMuxClock, {CHAN_COUNT{c[0]}});
		end
		@(posedge clk);
		loopConnect <= '1;
		repeat (2) @(negedge clk);
		check(txMuxData, ~rxDemuxData);
		check(txMuxClock, ~rxDemuxClock);
		// Mixed sources: group 2 idles, group 3 from pins, group 4 looped
		@(posedge clk);
		loopConnect <= {7'h7F, 14'h0000};
		wr(SEL_GROUP3_OFFSET, 8'h00);
		repeat (2) @(negedge clk);
		check(txMuxData, {~rxDemuxData[20:14], ~ds1_tx_data_pin[13:7], 7'h00});
		wr(RX_XBIT_OFFSET, 8'h00);
		rd(RX_XBIT_OFFSET, 8'h35);
		wr(TX_XBIT_OFFSET, 8'hAA);
		@(negedge clk);
		check(tx_ds2_xbit, 7'h2A);
		wr(TX_XBIT_OFFSET, 8'h7F);
		issue(TX_XBIT_OFFSET);
		issue(6'h00);
		@(negedge clk);
		check(readAccept, 1'h0);
		pop(8'h7F);
		pop(8'h00);
		rd(ALARM_LATCH_OFFSET, 8'h00);
		for (int i = 0; i < 8; i++) begin
			@(posedge clk);
			live <= 8'h01 << i;
			rd(ALARM_LATCH_OFFSET, 8'h01 << i);
			live <= 8'h00;
			rd(ALARM_LATCH_OFFSET, 8'h01 << i);
			rd(ALARM_LATCH_OFFSET, 8'h00);
		end
		// Two reads back to back, alarm raised in the first clearing cycle
		for (int k = 0; k < 2; k++) begin
			@(posedge clk);
			{chipSelect, readStrobe, readReady, regAddr} <= {3'h7, ALARM_LATCH_OFFSET};
			live <= k ? 8'h40 : 8'h81;
			@(posedge clk);
			live <= 8'h00;
			@(posedge clk);
			{chipSelect, readStrobe} <= 2'h0;
			@(negedge clk);
			check(readData, k ? 8'h40 : 8'h81);
			@(posedge clk);
			readReady <= 1'h0;
		end
		// Mid-run reset must drop the select bits and empty the read buffer
		@(posedge clk);
		rst <= 1'h1;
		@(negedge clk);
		check(readAccept, 1'h1);
		check(txMuxData, 21'h000000);
		@(posedge clk);
		rst <= 1'h0;
		rd(SEL_GROUP2_OFFSET, 8'h00);
		@(negedge clk);
		check(txMuxData, ~ds1_tx_data_pin);
		results();
	end
endmodule
